// ==== bench/cell_model.sv ====
// far side: charge source, discharge load and the cell voltage converter
// assumes the bench sets level, the no-load cell voltage, between samples
`timescale 1ns/100ps
`default_nettype none
module cell_model (
   input wire logic ref_clk,
   input wire logic charge_en,
   input wire logic disch_en,
   input wire logic adc_start,
   input wire logic slow,
   input wire logic [9:0] level,
   output logic adc_done,
   output logic [9:0] adc_data,
   output logic bad_sample
);
   logic [2:0] wait_ff = 3'h0;
   logic [9:0] held_ff = 10'h000;
   logic done_ff = 1'b0;
   logic [9:0] data_ff = 10'h000;
   logic bad_ff = 1'b0;
   logic source_on;
   logic sink_on;
   assign source_on = charge_en;
   assign sink_on = disch_en;
   assign adc_done = done_ff;
   assign adc_data = data_ff;
   assign bad_sample = bad_ff;
   always @(posedge ref_clk) begin
      if (adc_start) begin
         wait_ff <= slow ? 3'h4 : 3'h1;
         held_ff <= level;
         // a reading under load would not show the true charge state
         if (source_on || sink_on) bad_ff <= 1'b1;
      end else if (wait_ff != 3'h0) begin
         wait_ff <= wait_ff - 3'h1;
      end
      done_ff <= (wait_ff == 3'h1);
      // stale data toggles so it never passes for a result
      data_ff <= (wait_ff == 3'h1) ? held_ff : ~data_ff;
   end
endmodule
`default_nettype wire

// ==== bench/pulse_charge_termination_ctrl_bench.sv ====
// bench for the pulse charge sequencer: timing, maintenance, termination
// assumes short sim counts 20/5/10 and a ratio of 3; cell_model on far side
`timescale 1ns/100ps
`default_nettype none
module pulse_charge_termination_ctrl_bench;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] rate_sel = 2'h0;
   logic slow = 1'b0;
   logic [9:0] level = 10'h000;
   logic adc_start, adc_done, charge_en, disch_en, maint_mode, bad_sample;
   logic [9:0] adc_data;
   logic [31:0] slope_out;
   logic [7:0] rnd = 8'h24;
   logic pch = 1'b0;
   logic pdi = 1'b0;
   int bad_count = 0;
   int n_compared = 0;
   int notes[$];
   int pc, cc, dc, qc, note, seen;
   initial forever #5 ref_clk = ~ref_clk;
   pulse_charge_termination_ctrl #(.CHG_CYC(20), .DIS_CYC(5), .QUIET_CYC(10), .MAINT_RATIO(3))
      pulse_charge_termination_ctrl_i (.ref_clk(ref_clk), .srst(srst), .rate_sel(rate_sel),
      .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data), .charge_en(charge_en),
      .disch_en(disch_en), .maint_mode(maint_mode), .slope_out(slope_out));
   cell_model cell_model_i (.ref_clk(ref_clk), .charge_en(charge_en), .disch_en(disch_en),
      .adc_start(adc_start), .slow(slow), .level(level), .adc_done(adc_done),
      .adc_data(adc_data), .bad_sample(bad_sample));
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic wait_rise();
      logic was;
      int k;
      was = 1'b1;
      for (k = 0; k < 400 && !(charge_en === 1'b1 && was === 1'b0); k++) begin
         was = charge_en;
         @(negedge ref_clk);
      end
      if (k == 400) check("pair start", 0, 1);
   endtask
   // ****************************************************************
   // one pair per window; notes hold period*4 plus maint, 2 is any
   // ****************************************************************
   task automatic run(input int r, input int base, input int s1, input int turn, input int s2,
                      input int total, input int ok_to, input int sure);
      int v;
      srst = 1'b1;
      rate_sel = r[1:0];
      rnd = lfsr(rnd);
      slow = rnd[0];
      repeat (2) @(negedge ref_clk);
      check("reset charge", charge_en, 1);
      check("reset maint", maint_mode, 0);
      srst = 1'b0;
      for (int w = 0; w < total; w++) begin
         if (w > 0) wait_rise();
         // steps are in sixteenths of a level per window
         v = base + ((w < turn) ? s1 * w : s1 * turn + s2 * (w - turn)) / 16;
         level = 10'(v);
         notes.push_back(w < ok_to ? (w > 0 ? 140 : 0) : (w >= sure ? 421 : 2));
      end
      wait_rise();
      // let the monitor pop the last note before reset silences it
      @(negedge ref_clk);
   endtask
   always @(negedge ref_clk) begin
      if (srst) begin
         pc = 0;
         cc = 0;
         dc = 0;
         qc = 99;
         seen = 0;
      end else begin
         pc++;
         if (charge_en && !pch) begin
            if (notes.size() > 0) begin
               note = notes.pop_front();
               if (note / 4 != 0) check("pair period", pc, note / 4);
               if (note % 4 != 2) check("maintenance", maint_mode, note % 4);
            end
            pc = 0;
            cc = 0;
            seen = 1;
         end
         if (pch && !charge_en && seen == 1) begin
            check("charge length", cc, 20);
            check("discharge follows", disch_en, 1);
         end
         if (pdi && !disch_en) begin
            check("discharge length", dc, 5);
            check("quiet start", charge_en, 0);
            dc = 0;
            qc = 0;
         end
         if (adc_start) check("sample place", qc < 10 && !charge_en && !disch_en, 1);
         cc += charge_en;
         dc += disch_en;
         qc++;
      end
      pch = charge_en;
      pdi = disch_en;
   end
   initial begin
      for (int r = 0; r < 4; r++) begin
         rnd = lfsr(rnd);
         // half a level per push at every rate: well under the rise limit
         run(r, rnd[3:0], 8 >> r, 999, 0, (16 << r) + 2, 999, 999);
      end
      run(0, 600, -128, 999, 0, 45, 11, 40);
      // slow fall: slopes stay small, only the negative run can end it
      run(0, 600, -4, 999, 0, 20, 11, 16);
      run(0, 100, 320, 999, 0, 45, 11, 40);
      run(0, 100, 8, 20, 0, 65, 11, 60);
      check("no-load sample", bad_sample, 0);
      conclude();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire

// ==== logic/pulse_charge_termination_ctrl.sv ====
// pulse charge sequencer with slope-based termination to maintenance
// assumes an external current source and load follow charge_en/disch_en
`timescale 1ns/100ps
`default_nettype none
`include "charge_params.svh"
module pulse_charge_termination_ctrl #(
   parameter int CHG_CYC = `CHG_PULSE_CYC,
   parameter int DIS_CYC = `DIS_PULSE_CYC,
   parameter int QUIET_CYC = `QUIET_CYC,
   parameter int MAINT_RATIO = `MAINT_RATIO
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [1:0] rate_sel,
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [`ADC_BITS-1:0] adc_data,
   output logic charge_en,
   output logic disch_en,
   output logic maint_mode,
   output logic [31:0] slope_out
);
   localparam int FW = 16;
   localparam int N = `FIFO_DEPTH;

   // ****************************************
   // sequencer
   // ****************************************
   charge_pkg::seq_state_e st_ff, nxt_st;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [7:0] skip_ff, nxt_skip;
   logic maint_ff, nxt_maint;
   logic sampled_ff, nxt_sampled;
   logic terminate;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff + 32'h1;
      nxt_skip = skip_ff;
      nxt_maint = maint_ff | terminate;
      nxt_sampled = sampled_ff;
      case (st_ff)
         charge_pkg::ST_CHARGE: begin
            if (cnt_ff >= 32'(CHG_CYC - 1)) begin
               nxt_st = charge_pkg::ST_DISCH;
               nxt_cnt = '0;
            end
         end
         charge_pkg::ST_DISCH: begin
            if (cnt_ff >= 32'(DIS_CYC - 1)) begin
               nxt_st = charge_pkg::ST_QUIET;
               nxt_cnt = '0;
               nxt_sampled = 1'b0;
            end
         end
         charge_pkg::ST_QUIET: begin
            if (adc_start)
               nxt_sampled = 1'b1;
            if (cnt_ff >= 32'(QUIET_CYC - 1)) begin
               nxt_cnt = '0;
               if (maint_ff || terminate) begin
                  nxt_st = charge_pkg::ST_IDLE;
                  nxt_skip = '0;
               end else
                  nxt_st = charge_pkg::ST_CHARGE;
            end
         end
         charge_pkg::ST_IDLE: begin
            // idle for whole pair periods so the average drops sixty-fold
            if (cnt_ff >= 32'(CHG_CYC + DIS_CYC + QUIET_CYC - 1)) begin
               nxt_cnt = '0;
               nxt_skip = skip_ff + 8'h1;
               if (skip_ff >= 8'(MAINT_RATIO - 2)) begin
                  nxt_st = charge_pkg::ST_CHARGE;
                  nxt_skip = '0;
               end
            end
         end
         default: begin
            nxt_st = charge_pkg::ST_CHARGE;
            nxt_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_ff <= charge_pkg::ST_CHARGE;
         cnt_ff <= '0;
         skip_ff <= '0;
         maint_ff <= 1'b0;
         sampled_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         skip_ff <= nxt_skip;
         maint_ff <= nxt_maint;
         sampled_ff <= nxt_sampled;
      end
   end

   assign charge_en = (st_ff == charge_pkg::ST_CHARGE);
   assign disch_en = (st_ff == charge_pkg::ST_DISCH);
   assign maint_mode = maint_ff;
   // one conversion request from halfway through the quiet window
   assign adc_start = (st_ff == charge_pkg::ST_QUIET) && !sampled_ff
      && (cnt_ff >= 32'(QUIET_CYC / 2));

   // ****************************************
   // averaging, filter and queue
   // ****************************************
   logic [3:0] avg_n;
   logic [3:0] acnt_ff, nxt_acnt;
   logic [FW-1:0] acc_ff, nxt_acc;
   logic [FW-1:0] iir_ff, nxt_iir;
   logic iir_init_ff, nxt_iir_init;
   logic [N*FW-1:0] q_ff, nxt_q;
   logic [3:0] fill_ff, nxt_fill;
   logic push;
   logic iir_push_ff;
   logic [FW-1:0] avg_val;

   always_comb begin
      case (rate_sel)
         2'h0: avg_n = 4'h1;
         2'h1: avg_n = 4'h2;
         2'h2: avg_n = 4'h4;
         default: avg_n = 4'h8;
      endcase
   end

   always_comb begin
      nxt_acc = acc_ff;
      nxt_acnt = acnt_ff;
      push = 1'b0;
      avg_val = '0;
      if (adc_done) begin
         nxt_acc = acc_ff + FW'(adc_data);
         nxt_acnt = acnt_ff + 4'h1;
         if (acnt_ff + 4'h1 >= avg_n) begin
            push = 1'b1;
            nxt_acnt = '0;
            nxt_acc = '0;
         end
      end
      case (avg_n)
         4'h2: avg_val = FW'((acc_ff + FW'(adc_data)) >> 1);
         4'h4: avg_val = FW'((acc_ff + FW'(adc_data)) >> 2);
         4'h8: avg_val = FW'((acc_ff + FW'(adc_data)) >> 3);
         default: avg_val = FW'(adc_data);
      endcase
      // weight 1/4 new, 3/4 old, scaled by 16 for resolution
      nxt_iir = iir_ff;
      nxt_iir_init = iir_init_ff;
      if (push) begin
         nxt_iir_init = 1'b1;
         if (!iir_init_ff)
            nxt_iir = FW'(avg_val << 4);
         else
            nxt_iir = FW'(iir_ff - (iir_ff >> 2) + ((avg_val << 4) >> 2));
      end
      nxt_q = q_ff;
      nxt_fill = fill_ff;
      if (iir_push_ff) begin
         nxt_q = {iir_ff, q_ff[N*FW-1:FW]};
         if (fill_ff < 4'(N))
            nxt_fill = fill_ff + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         acc_ff <= '0;
         acnt_ff <= '0;
         iir_ff <= '0;
         iir_init_ff <= 1'b0;
         q_ff <= '0;
         fill_ff <= '0;
         iir_push_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         acnt_ff <= nxt_acnt;
         iir_ff <= nxt_iir;
         iir_init_ff <= nxt_iir_init;
         q_ff <= nxt_q;
         fill_ff <= nxt_fill;
         iir_push_ff <= push;
      end
   end

   // ****************************************
   // slope and termination
   // ****************************************
   logic signed [31:0] slope;
   logic signed [31:0] prev_ff, nxt_prev, peak_ff, nxt_peak;
   logic [3:0] neg_ff, nxt_neg;
   logic calc_ff, full;

   slope_calc #(.N(N), .W(FW)) u_slope (
      .window(q_ff),
      .slope(slope)
   );

   assign full = (fill_ff == 4'(N));

   always_comb begin
      nxt_prev = prev_ff;
      nxt_peak = peak_ff;
      nxt_neg = neg_ff;
      terminate = 1'b0;
      if (calc_ff && full && !maint_ff) begin
         nxt_prev = slope;
         if (slope > peak_ff)
            nxt_peak = slope;
         nxt_neg = (slope < 0) ? ((neg_ff < 4'hf) ? neg_ff + 4'h1 : neg_ff) : 4'h0;
         // cutoff: slope has fallen to a fraction of its running peak
         if (peak_ff > 0 && slope <= (peak_ff >>> `CUT_FRAC_SHIFT) && slope >= 0)
            terminate = 1'b1;
         if (nxt_neg >= 4'(`NEG_RUN))
            terminate = 1'b1;
         if (slope > `RISE_LIMIT)
            terminate = 1'b1;
         if (prev_ff - slope > `DROP_LIMIT)
            terminate = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prev_ff <= '0;
         peak_ff <= '0;
         neg_ff <= '0;
         calc_ff <= 1'b0;
         slope_out <= '0;
      end else begin
         prev_ff <= nxt_prev;
         peak_ff <= nxt_peak;
         neg_ff <= nxt_neg;
         calc_ff <= iir_push_ff;
         slope_out <= calc_ff ? slope : slope_out;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   quiet_off_a: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(disch_en) |-> !charge_en && !disch_en) else $error("pulse during quiet");
   sample_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
      adc_start |-> !charge_en && !disch_en) else $error("sample under load");
   no_overlap_a: assert property (@(posedge ref_clk) disable iff (srst)
      !(charge_en && disch_en)) else $error("both enables high");
   maint_stays_a: assert property (@(posedge ref_clk) disable iff (srst)
      maint_mode |=> maint_mode) else $error("left maintenance");
   term_full_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(maint_mode) |-> $past(full)) else $error("early termination");
   disch_after_a: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(charge_en) && !srst |-> disch_en) else $error("no discharge");
   fill_cap_a: assert property (@(posedge ref_clk) disable iff (srst)
      fill_ff <= 4'(N)) else $error("queue overfilled");
   neg_term_a: assert property (@(posedge ref_clk) disable iff (srst)
      calc_ff && full && !maint_mode && nxt_neg >= 4'(`NEG_RUN) |=> maint_mode)
      else $error("negative run ignored");
endmodule
`default_nettype wire

// ==== logic/slope_calc.sv ====
// least-squares slope over a full sample window
// assumes samples are presented oldest first at index 0
`timescale 1ns/100ps
`default_nettype none
module slope_calc #(
   parameter int N = 12,
   parameter int W = 16
) (
   input wire logic [N*W-1:0] window,
   output logic signed [31:0] slope
);
   logic signed [47:0] sxy, sy, num, den;
   always_comb begin
      sxy = '0;
      sy = '0;
      for (int i = 0; i < N; i++) begin
         sxy = sxy + 48'(i) * 48'(window[i*W +: W]);
         sy = sy + 48'(window[i*W +: W]);
      end
      // x runs 0..N-1, so the x sums are constants
      num = 48'(N) * sxy - 48'(N*(N-1)/2) * sy;
      den = 48'(N*(N-1)*(2*N-1)/6 * N - (N*(N-1)/2) * (N*(N-1)/2));
      // scaled by 256 to keep fraction bits
      slope = 32'((num * 48'sh100) / den);
   end
endmodule
`default_nettype wire

// ==== pkg/charge_params.svh ====
// constants for the pulse charge sequencer: timing counts and thresholds
// assumes a 100 MHz ref_clk; counts derive from times in their own unit
`ifndef CHARGE_PARAMS_SVH
`define CHARGE_PARAMS_SVH
`define CLK_MHZ 100
`define QUIET_MS 10
`define QUIET_CYC (`QUIET_MS * 1000 * `CLK_MHZ)
`define CHG_PULSE_MS 980
`define CHG_PULSE_CYC (`CHG_PULSE_MS * 1000 * `CLK_MHZ)
`define DIS_PULSE_US 5000
`define DIS_PULSE_CYC (`DIS_PULSE_US * `CLK_MHZ)
`define MAINT_RATIO 60
`define ADC_BITS 10
`define FIFO_DEPTH 12
`define NEG_RUN 3
`define RISE_LIMIT 32'sh00000fa0
`define DROP_LIMIT 32'sh000007d0
`define CUT_FRAC_SHIFT 2
`endif

// ==== pkg/charge_pkg.sv ====
// types shared by the charge sequencer files
// assumes charge_params.svh is included where counts are needed
package charge_pkg;
   typedef enum logic [4:0] {
      ST_CHARGE = 5'h01,
      ST_DISCH  = 5'h02,
      ST_QUIET  = 5'h04,
      ST_CALC   = 5'h08,
      ST_IDLE   = 5'h10
   } seq_state_e;
   typedef logic [9:0] sample_t;
endpackage
